/* File: timer_waveform_pkg.sv */
// constants, types and carriers for the 8-bit timer waveform mode block
//
// Functional notes
// - only mode field picks count sequence
// - normal mode increments and wraps FF to 00
// - normal overflow flag sets when count hits zero
// - mode 2 clears count on compare A match
// - mode 2 compare A written directly, unbuffered
// - mode 2 compare A flag sets every period
// - mode 2 action 1 toggles output A
// - mode 2 overflow sets on FF to 00
// - modes 3/7 fast PWM, top FF or A
// - fast PWM clears count after top cycle
// - fast PWM overflow flag sets at top
// - fast PWM action 2 clear/set, 3 inverse
// - PWM action 1 toggles A only if bit2
// - fast PWM keeps compare double buffering always
// - fast PWM extremes give spike or constant level
// - modes 1/5 phase correct, top FF or A
// - phase correct holds top one cycle, reverses
// - phase correct overflow flag sets at bottom
// - phase correct clear up, set down, or inverse
// - phase correct compare extremes give constant levels
// - phase correct forces up-match level for symmetry
// - counter write beats clear and count
// - compare match sets flag next timer cycle
// - compare buffered in PWM, direct otherwise
// - clock select zero stops counting, flags and waveform
package timer_waveform_pkg;

    // counter extremes
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;

    // waveform mode field values
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_PC_FULL = 3'h1;
    localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
    localparam logic [2:0] MODE_FAST_FULL = 3'h3;
    localparam logic [2:0] MODE_PC_TOP_A = 3'h5;
    localparam logic [2:0] MODE_FAST_TOP_A = 3'h7;

    // output action field values
    localparam logic [1:0] ACTION_NONE = 2'h0;
    localparam logic [1:0] ACTION_TOGGLE = 2'h1;
    localparam logic [1:0] ACTION_CLEAR = 2'h2;
    localparam logic [1:0] ACTION_SET = 2'h3;

    // clock select value that halts the counter
    localparam logic [2:0] CLOCK_STOPPED = 3'h0;

    // count direction, one-hot
    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } dir_type;

    // software configuration carrier
    typedef struct packed {
        logic [2:0] waveform_mode_sel;
        logic [2:0] clock_select;
        logic [1:0][1:0] output_action_sel; // index 0 is channel A
    } timer_config_type;

    // all state of the block
    typedef struct packed {
        logic [7:0] count;
        dir_type dir;
        logic [1:0][7:0] cmp; // active compare values
        logic overflow;
        logic [1:0] flag;
        logic [1:0] wave;
        logic [1:0] wave_en;
        logic [1:0] sync; // pending symmetry fix-up
        logic block; // match blocked after a counter write
    } timer_state_type;

    // reset values
    localparam timer_state_type STATE_RESET = '{
        count: COUNT_BOTTOM,
        dir: DIR_UP,
        cmp: '0,
        overflow: 1'b0,
        flag: 2'b00,
        wave: 2'b00,
        wave_en: 2'b00,
        sync: 2'b00,
        block: 1'b0
    };

endpackage

/* File: timer_waveform_modes.sv */
// counter, compare, flag and waveform logic of the 8-bit timer
module timer_waveform_modes
    import timer_waveform_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic timer_tick,
    input wire timer_config_type cfg,
    input wire logic [1:0][7:0] compare_value,
    input wire logic count_write,
    input wire logic [7:0] count_write_data,
    input wire logic overflow_clear,
    input wire logic [1:0] compare_flag_clear,
    output logic [7:0] count_value,
    output logic count_down,
    output logic overflow_flag,
    output logic compare_a_flag,
    output logic compare_b_flag,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic wave_a_override,
    output logic wave_b_override
);

    ////////////////////////////////////////////////////////////////////////////////
    // mode decode

    timer_state_type state_q; // registered state
    timer_state_type state_d; // next state
    logic run; // one timer clock edge
    logic is_clear_on_match;
    logic is_fast;
    logic is_pc;
    logic is_pwm;
    logic waveform_mode_bit2;
    logic [7:0] top_value;
    logic at_top;
    logic at_bottom;
    logic [1:0] match; // unblocked compare equality
    logic [1:0] wave_next;
    logic [1:0] wave_en_next;
    logic [1:0][7:0] cmp_next;
    logic [1:0] sync_next;

    // stopped clock select keeps every edge idle, counter still writable
    assign run = timer_tick && (cfg.clock_select != CLOCK_STOPPED);
    // counting sequence comes from the mode field only; actions never enter here
    assign waveform_mode_bit2 = cfg.waveform_mode_sel[2];
    assign is_clear_on_match = cfg.waveform_mode_sel == MODE_CLEAR_ON_MATCH;
    assign is_fast = (cfg.waveform_mode_sel == MODE_FAST_FULL) ||
                     (cfg.waveform_mode_sel == MODE_FAST_TOP_A);
    assign is_pc = (cfg.waveform_mode_sel == MODE_PC_FULL) ||
                   (cfg.waveform_mode_sel == MODE_PC_TOP_A);
    // modes 4 and 6 fall through to normal counting
    assign is_pwm = is_fast || is_pc;
    // top is compare A only in PWM modes with bit 2 set
    assign top_value = (is_pwm && waveform_mode_bit2) ? state_q.cmp[0] : COUNT_MAX;
    assign at_top = state_q.count == top_value;
    assign at_bottom = state_q.count == COUNT_BOTTOM;

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel compare, buffering and waveform

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [1:0] act;
        logic up_match; // match treated as an up-count match
        assign act = cfg.output_action_sel[ch];
        // a counter write hides the match on the following timer edge
        assign match[ch] = (state_q.count == state_q.cmp[ch]) && !state_q.block;
        // bottom counts as up, top as down, so extremes give steady levels
        assign up_match = at_bottom || (!at_top && state_q.dir == DIR_UP);

        // compare buffer: direct in non-PWM, loaded at top in PWM
        always_comb begin
            cmp_next[ch] = state_q.cmp[ch];
            if (!is_pwm) begin
                cmp_next[ch] = compare_value[ch];
            end else if (run && at_top) begin
                // fast PWM keeps buffering even while A toggles
                cmp_next[ch] = compare_value[ch];
            end
        end

        // symmetry fix-up: armed when compare leaves max or count starts above it
        always_comb begin
            sync_next[ch] = state_q.sync[ch];
            if (!is_pc) begin
                sync_next[ch] = 1'b0;
            end else if (count_write && count_write_data > state_q.cmp[ch]) begin
                sync_next[ch] = 1'b1;
            end else if (state_q.cmp[ch] == COUNT_MAX && cmp_next[ch] != COUNT_MAX) begin
                sync_next[ch] = 1'b1;
            end else if (run && at_bottom) begin
                sync_next[ch] = 1'b0;
            end
        end

        // pin override: reserved toggle in PWM leaves the pin to the port
        always_comb begin
            wave_en_next[ch] = act != ACTION_NONE;
            if (is_pwm && act == ACTION_TOGGLE && (ch != 0 || !waveform_mode_bit2)) begin
                wave_en_next[ch] = 1'b0;
            end
        end

        // waveform register update on each timer edge
        always_comb begin
            wave_next[ch] = state_q.wave[ch];
            if (run) begin
                if (!is_pwm) begin
                    // non-PWM: toggle, clear or set on match
                    if (match[ch]) begin
                        case (act)
                            ACTION_TOGGLE: begin
                                wave_next[ch] = !state_q.wave[ch];
                            end
                            ACTION_CLEAR: begin
                                wave_next[ch] = 1'b0;
                            end
                            ACTION_SET: begin
                                wave_next[ch] = 1'b1;
                            end
                            default: begin
                                wave_next[ch] = state_q.wave[ch];
                            end
                        endcase
                    end
                end else if (is_fast) begin
                    if (at_top && act[1]) begin
                        // top to bottom: set for action 2, clear for 3; wins over match at top
                        wave_next[ch] = act == ACTION_CLEAR;
                    end else if (match[ch] && act[1]) begin
                        wave_next[ch] = act == ACTION_SET;
                    end else if (match[ch] && act == ACTION_TOGGLE && waveform_mode_bit2 && ch == 0) begin
                        wave_next[ch] = !state_q.wave[ch];
                    end
                end else begin
                    if (state_q.sync[ch] && at_bottom && act[1]) begin
                        // forced up-count level without a match
                        wave_next[ch] = act == ACTION_SET;
                    end else if (match[ch] && act[1]) begin
                        // up: clear for 2, set for 3; down the reverse
                        wave_next[ch] = up_match ? (act == ACTION_SET) : (act == ACTION_CLEAR);
                    end else if (match[ch] && act == ACTION_TOGGLE && waveform_mode_bit2 && ch == 0) begin
                        wave_next[ch] = !state_q.wave[ch];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter, direction and flags

    always_comb begin
        state_d = state_q;
        state_d.cmp = cmp_next;
        state_d.sync = sync_next;
        state_d.wave = wave_next;
        state_d.wave_en = wave_en_next;
        if (count_write) begin
            // software write wins over any count or clear, and blocks next match
            state_d.count = count_write_data;
            state_d.block = 1'b1;
        end else if (run) begin
            state_d.block = 1'b0;
            if (is_fast) begin
                state_d.dir = DIR_UP;
                state_d.count = at_top ? COUNT_BOTTOM : state_q.count + COUNT_ONE;
            end else if (is_pc) begin
                if (state_q.dir == DIR_UP && at_top) begin
                    // top seen for one edge, then head down
                    state_d.dir = DIR_DOWN;
                    state_d.count = (top_value == COUNT_BOTTOM) ? COUNT_BOTTOM : top_value - COUNT_ONE;
                end else if (state_q.dir == DIR_DOWN && at_bottom) begin
                    state_d.dir = DIR_UP;
                    state_d.count = (top_value == COUNT_BOTTOM) ? COUNT_BOTTOM : COUNT_ONE;
                end else if (state_q.dir == DIR_UP) begin
                    state_d.count = state_q.count + COUNT_ONE;
                end else begin
                    state_d.count = state_q.count - COUNT_ONE;
                end
            end else if (is_clear_on_match && state_q.count == state_q.cmp[0]) begin
                // a missed match runs on to FF and wraps first
                state_d.dir = DIR_UP;
                state_d.count = COUNT_BOTTOM;
            end else begin
                // normal wraps FF to 00 with no hardware clear
                state_d.dir = DIR_UP;
                state_d.count = state_q.count + COUNT_ONE;
            end
        end
        // overflow: set wins over a clear in the same cycle
        state_d.overflow = state_q.overflow && !overflow_clear;
        if (run && !count_write) begin
            if (is_fast && at_top) begin
                state_d.overflow = 1'b1;
            end else if (is_pc && state_q.dir == DIR_DOWN && state_q.count == COUNT_ONE) begin
                state_d.overflow = 1'b1;
            end else if (!is_pwm && state_q.count == COUNT_MAX) begin
                state_d.overflow = 1'b1;
            end
        end
        // compare flags land on the timer edge after equality is seen
        state_d.flag = (state_q.flag & ~compare_flag_clear) | (run ? match : 2'b00);
    end

    // state register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from state flip-flops
    assign count_value = state_q.count;
    assign count_down = state_q.dir == DIR_DOWN;
    assign overflow_flag = state_q.overflow;
    assign compare_a_flag = state_q.flag[0];
    assign compare_b_flag = state_q.flag[1];
    assign wave_out_a = state_q.wave[0];
    assign wave_out_b = state_q.wave[1];
    assign wave_a_override = state_q.wave_en[0];
    assign wave_b_override = state_q.wave_en[1];

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    logic normal_like; // modes 0, 4, 6
    assign normal_like = !is_clear_on_match && !is_pwm;

    // leaving top: the counter restarts at bottom and overflow rises on that same edge
    sequence s_fast_at_top;
        run && is_fast && !count_write && at_top;
    endsequence

    sequence s_fast_restart;
        count_value == COUNT_BOTTOM && overflow_flag;
    endsequence

    property p_normal_wrap;
        @(posedge ref_clk) disable iff (!reset_n)
        (run && normal_like && !count_write && count_value == COUNT_MAX)
            |=> (count_value == COUNT_BOTTOM && overflow_flag);
    endproperty
    a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow wrong");

    property p_write_priority;
        @(posedge ref_clk) disable iff (!reset_n)
        count_write |=> count_value == $past(count_write_data);
    endproperty
    a_write_priority: assert property (p_write_priority) else $error("counter write lost");

    property p_stopped;
        @(posedge ref_clk) disable iff (!reset_n)
        (cfg.clock_select == CLOCK_STOPPED && !count_write) |=> $stable(count_value);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

    property p_match_clear;
        @(posedge ref_clk) disable iff (!reset_n)
        (run && is_clear_on_match && !count_write && count_value == state_q.cmp[0])
            |=> count_value == COUNT_BOTTOM;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("match did not clear counter");

    property p_match_toggle_a;
        @(posedge ref_clk) disable iff (!reset_n)
        (run && is_clear_on_match && match[0] && cfg.output_action_sel[0] == ACTION_TOGGLE)
            |=> wave_out_a != $past(wave_out_a);
    endproperty
    a_match_toggle_a: assert property (p_match_toggle_a) else $error("output A did not toggle on match");

    property p_match_flag;
        @(posedge ref_clk) disable iff (!reset_n)
        (run && count_value == state_q.cmp[0] && !state_q.block) |=> compare_a_flag;
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("compare flag not set");

    property p_pc_top;
        @(posedge ref_clk) disable iff (!reset_n)
        (run && is_pc && !count_write && !count_down && at_top && top_value != COUNT_BOTTOM)
            |=> (count_down && count_value + COUNT_ONE == $past(count_value));
    endproperty
    a_pc_top: assert property (p_pc_top) else $error("top not held one cycle");

    property p_fast_top;
        @(posedge ref_clk) disable iff (!reset_n)
        s_fast_at_top |=> s_fast_restart;
    endproperty
    a_fast_top: assert property (p_fast_top) else $error("fast PWM top handling wrong");

    property p_pc_bottom;
        @(posedge ref_clk) disable iff (!reset_n)
        (run && is_pc && !count_write && count_down && count_value == COUNT_ONE)
            |=> (count_value == COUNT_BOTTOM && overflow_flag);
    endproperty
    a_pc_bottom: assert property (p_pc_bottom) else $error("bottom overflow missing");

    property p_fast_set_at_top;
        @(posedge ref_clk) disable iff (!reset_n)
        (run && is_fast && at_top && cfg.output_action_sel[0] == ACTION_CLEAR) |=> wave_out_a;
    endproperty
    a_fast_set_at_top: assert property (p_fast_set_at_top) else $error("output A not set at top");

endmodule

/* File: testbench.sv */
// self-checking testbench for the 8-bit timer waveform mode block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_waveform_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic timer_tick = 1'b0; // prescaler enable, driven per scenario
    timer_config_type cfg = '0;
    logic [1:0][7:0] compare_value = '0;
    logic count_write = 1'b0;
    logic [7:0] count_write_data = 8'h00;
    logic overflow_clear = 1'b0;
    logic [1:0] compare_flag_clear = 2'b00;
    logic [7:0] count_value;
    logic count_down;
    logic overflow_flag;
    logic compare_a_flag;
    logic compare_b_flag;
    logic wave_out_a;
    logic wave_out_b;
    logic wave_a_override;
    logic wave_b_override;
    int n_fail = 0; // mismatches
    int checks_done = 0; // comparisons made

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    timer_waveform_modes i_timer_waveform_modes (
        .ref_clk(ref_clk), .reset_n(reset_n), .timer_tick(timer_tick), .cfg(cfg),
        .compare_value(compare_value), .count_write(count_write), .count_write_data(count_write_data),
        .overflow_clear(overflow_clear), .compare_flag_clear(compare_flag_clear),
        .count_value(count_value), .count_down(count_down), .overflow_flag(overflow_flag),
        .compare_a_flag(compare_a_flag), .compare_b_flag(compare_b_flag), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b), .wave_a_override(wave_a_override), .wave_b_override(wave_b_override)
    );

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    // four-state compare so an unknown never matches
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one edge, then a fixed settle delay so outputs and new inputs never race
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask

    // compare values go in while in normal mode, where they load directly
    task automatic setup(input logic [2:0] m, input logic [1:0] aa, input logic [1:0] ab,
                         input logic [7:0] ca, input logic [7:0] cb);
        cfg.clock_select = 3'h1;
        cfg.waveform_mode_sel = MODE_NORMAL;
        cfg.output_action_sel[0] = aa;
        cfg.output_action_sel[1] = ab;
        compare_value[0] = ca;
        compare_value[1] = cb;
        step;
        cfg.waveform_mode_sel = m;
        step;
    endtask

    task automatic load(input logic [7:0] v);
        count_write = 1'b1;
        count_write_data = v;
        step;
        count_write = 1'b0;
    endtask

    task automatic clear_flags;
        overflow_clear = 1'b1;
        compare_flag_clear = 2'b11;
        step;
        overflow_clear = 1'b0;
        compare_flag_clear = 2'b00;
    endtask

    // bounded wait for a count value; running out ends the run
    task automatic run_to(input logic [7:0] v);
        int k;
        k = 0;
        while (count_value !== v && k < 600) begin
            step;
            k++;
        end
        if (count_value !== v) begin
            n_fail++;
            finish_test;
        end
    endtask

    // expected counter in normal mode: write beats counting, stop beats tick
    function automatic logic [7:0] next_count(input logic [7:0] c, input logic run, input logic wr,
                                              input logic [7:0] d);
        if (wr) begin
            return d;
        end
        return run ? c + 8'h01 : c;
    endfunction

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [2:0] modes [3];
        logic [7:0] e;
        logic eo;
        logic run;
        logic w;
        modes = '{MODE_NORMAL, 3'h4, 3'h6};
        e = 8'($urandom(32'h9a80));
        repeat (8) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        check("reset count", count_value, 8'h00);
        timer_tick = 1'b1;
        // normal and reserved modes wrap with overflow; actions leave count alone
        for (int i = 0; i < 3; i++) begin
            setup(modes[i], ACTION_CLEAR, ACTION_SET, 8'h10, 8'h20);
            clear_flags;
            load(8'hFE);
            step;
            check("count", count_value, 8'hFF);
            check("ovf", 8'(overflow_flag), 8'h00);
            step;
            check("count", count_value, 8'h00);
            check("ovf", 8'(overflow_flag), 8'h01);
        end
        $display("normal mode test done");
        // clear on match: period of four, flag and toggle each period
        setup(MODE_CLEAR_ON_MATCH, ACTION_TOGGLE, ACTION_NONE, 8'h03, 8'h80);
        load(8'h00);
        w = wave_out_a;
        repeat (3) step;
        check("count", count_value, 8'h03);
        check("cmp flag", 8'(compare_a_flag), 8'h00);
        step;
        check("count", count_value, 8'h00);
        check("cmp flag", 8'(compare_a_flag), 8'h01);
        check("wave a", 8'(wave_out_a), {7'h00, ~w});
        repeat (4) step;
        check("wave a", 8'(wave_out_a), {7'h00, w});
        // top below the count: match is missed until after the wrap
        clear_flags;
        load(8'h10);
        repeat (8'hEF) step;
        check("count", count_value, 8'hFF);
        step;
        check("ovf", 8'(overflow_flag), 8'h01);
        check("cmp flag", 8'(compare_a_flag), 8'h00);
        repeat (4) step;
        check("count", count_value, 8'h00);
        check("cmp flag", 8'(compare_a_flag), 8'h01);
        $display("clear on match test done");
        // fast pwm with full top, both polarities
        for (int i = 0; i < 2; i++) begin
            setup(MODE_FAST_FULL, i ? ACTION_SET : ACTION_CLEAR, ACTION_NONE, 8'h80, 8'h00);
            clear_flags;
            load(8'hFE);
            step;
            check("ovf", 8'(overflow_flag), 8'h00);
            step;
            check("count", count_value, 8'h00);
            check("ovf", 8'(overflow_flag), 8'h01);
            check("wave a", 8'(wave_out_a), i ? 8'h00 : 8'h01);
            repeat (8'h80) step;
            check("wave a", 8'(wave_out_a), i ? 8'h00 : 8'h01);
            step;
            check("wave a", 8'(wave_out_a), i ? 8'h01 : 8'h00);
        end
        // compare at max: top action wins over the match there, level never drops
        setup(MODE_FAST_FULL, ACTION_CLEAR, ACTION_NONE, 8'hFF, 8'h00);
        load(8'hFE);
        repeat (2) step;
        check("wave a", 8'(wave_out_a), 8'h01);
        repeat (8'hFF) step;
        check("count", count_value, 8'hFF);
        check("wave a", 8'(wave_out_a), 8'h01);
        step;
        check("wave a", 8'(wave_out_a), 8'h01);
        // fast pwm with top from compare a and toggle on a only
        setup(MODE_FAST_TOP_A, ACTION_TOGGLE, ACTION_TOGGLE, 8'h05, 8'h02);
        clear_flags;
        load(8'h00);
        w = wave_out_a;
        repeat (5) step;
        check("count", count_value, 8'h05);
        check("cmp b flag", 8'(compare_b_flag), 8'h01);
        step;
        check("count", count_value, 8'h00);
        check("wave a", 8'(wave_out_a), {7'h00, ~w});
        check("ovf", 8'(overflow_flag), 8'h01);
        check("ovr a", 8'(wave_a_override), 8'h01);
        check("ovr b", 8'(wave_b_override), 8'h00);
        cfg.waveform_mode_sel = MODE_FAST_FULL;
        repeat (2) step;
        check("ovr a", 8'(wave_a_override), 8'h00);
        $display("fast pwm test done");
        // phase correct: hold top one cycle, turn, overflow at bottom
        timer_tick = 1'b0;
        setup(MODE_PC_FULL, ACTION_CLEAR, ACTION_SET, 8'h40, 8'h40);
        load(8'hFD);
        timer_tick = 1'b1;
        repeat (2) step;
        check("count", count_value, 8'hFF);
        step;
        check("count", count_value, 8'hFE);
        check("down", 8'(count_down), 8'h01);
        clear_flags;
        run_to(8'h40);
        step;
        check("wave a", 8'(wave_out_a), 8'h01);
        check("wave b", 8'(wave_out_b), 8'h00);
        run_to(8'h01);
        check("ovf", 8'(overflow_flag), 8'h00);
        step;
        check("ovf", 8'(overflow_flag), 8'h01);
        step;
        check("down", 8'(count_down), 8'h00);
        // the load above the compare missed the up match, so bottom forces that level
        check("wave a", 8'(wave_out_a), 8'h00);
        check("wave b", 8'(wave_out_b), 8'h01);
        run_to(8'h40);
        step;
        check("wave a", 8'(wave_out_a), 8'h00);
        check("wave b", 8'(wave_out_b), 8'h01);
        $display("phase correct test done");
        // random ticks, stops, writes and overflow clears in normal mode
        setup(MODE_NORMAL, ACTION_NONE, ACTION_NONE, 8'h00, 8'h00);
        for (int i = 0; i < 400; i++) begin
            timer_tick = 1'($urandom);
            cfg.clock_select = (i % 50 < 10) ? CLOCK_STOPPED : 3'($urandom);
            count_write = ($urandom_range(7) == 0);
            count_write_data = (i % 3 == 0) ? 8'hFF : 8'($urandom);
            overflow_clear = ($urandom_range(3) == 0);
            run = timer_tick && cfg.clock_select != CLOCK_STOPPED;
            e = next_count(count_value, run, count_write, count_write_data);
            eo = (run && !count_write && count_value == 8'hFF) || (overflow_flag && !overflow_clear);
            step;
            check("count", count_value, e);
            check("ovf", 8'(overflow_flag), {7'h00, eo});
        end
        overflow_clear = 1'b0;
        count_write = 1'b0;
        $display("random normal test done");
        finish_test;
    end
endmodule
